//--- common/rcsp_defines.vh
// constants for the receiver configuration serial port
`ifndef RCSP_DEFINES_VH
`define RCSP_DEFINES_VH
`define RCSP_ADDR_PORT_CFG 13'h0000
`define RCSP_ADDR_SYNC_CTRL 13'h0100
`define RCSP_ADDR_QEC_CTRL 13'h0110
`define RCSP_ADDR_NSR_CTRL 13'h011e
`define RCSP_PORT_CFG_RST 8'h00
`define RCSP_SYNC_CTRL_RST 8'h00
`define RCSP_QEC_CTRL_RST 8'h00
`define RCSP_NSR_CTRL_RST 8'h00
`define RCSP_PORT_CFG_LSB_BIT 6
`define RCSP_SYNC_EN_BIT 0
`define RCSP_SYNC_ONCE_BIT 1
`define RCSP_NSR_EN_BIT 0
`define RCSP_INSTR_BITS 5'd16
`define RCSP_BYTE_BITS 4'd8
`endif

//--- core/rcsp_serial_port.v
// serial configuration port with sync, requantizer and correction controls
// Function
// - divider resync once or on every sync
// - sync input synchronised to sample clock
// - register requantizer_control bit 0 enables requantizer
// - bits 2:1 pick low, band, high pass
// - quadrature_correction_control bits 2:0 enable corrections, default off
// - quadrature_correction_control bits 5:3 freeze correction estimates
// - computed correction held while any enabled
// - port sampled on host serial clock
// - select low gates every transfer
// - frame starts first clock after select falls
// - select held low streams bytes while instr_q[14:13] is 11
// - select high between bytes pauses frame
// - select tied high floats pins, alternate use
// - 16-bit instruction then length-coded data
// - data moves in whole bytes
// - first bit marks read or write msb-first, last bit when lsb-first
// - read turns data line to output
// - msb first by default, lsb selectable
`timescale 1ns/1ps
`include "rcsp_defines.vh"
module rcsp_serial_port #(
	parameter ADDR_W = 13
) (
	input wire core_clk, // sample clock, 10 MHz
	input wire rst_n, // async reset, active low
	input wire ser_clk, // host serial clock pin
	input wire port_select_n, // host select pin
	input wire sdio_i, // data line level
	output reg sdio_o, // data line drive value
	output reg sdio_oe, // data line drive enable
	output reg port_idle_q, // select idle high, pins free for alternate use
	input wire sync_in, // external sync pin
	output reg div_resync, // one-cycle divider resync pulse
	output reg nsr_enable, // noise_shaping_requantizer on
	output reg [1:0] nsr_tuning, // requantizer tuning select
	output reg [2:0] qec_enable, // gain, phase, dc correction enables
	output reg [2:0] qec_freeze, // gain, phase, dc estimate freezes
	output reg qec_hold // keep computed correction applied
);
	// every pin goes through two flops; serial clock is oversampled by core_clk
	reg [1:0] sck_s;
	reg [1:0] sel_s;
	reg [1:0] dat_s;
	reg [1:0] syn_s;
	reg sck_prev_q;
	reg sel_prev_q;
	reg syn_prev_q;
	reg [7:0] port_cfg_q;
	reg [7:0] sync_ctrl_q;
	reg [7:0] qec_ctrl_q;
	reg [7:0] nsr_ctrl_q;
	reg qec_valid_q;
	reg sync_done_q;
	reg [15:0] instr_q;
	reg [4:0] bit_cnt_q;
	reg in_data_q;
	reg [7:0] shift_q;
	reg [ADDR_W-1:0] addr_q;
	reg [1:0] bytes_q;
	reg done_q;
	reg [7:0] rd_byte;
	wire lsb_first = port_cfg_q[`RCSP_PORT_CFG_LSB_BIT];
	wire sel_act = ~sel_s[1];
	wire sck_rise = sck_s[1] & ~sck_prev_q;
	wire sck_fall = ~sck_s[1] & sck_prev_q;
	wire sel_fall = sel_act & sel_prev_q;
	wire rd_op = instr_q[15];
	wire [7:0] wr_byte = lsb_first ?
		{dat_s[1], shift_q[7:1]} : {shift_q[6:0], dat_s[1]};
	wire [7:0] out_byte = bit_cnt_q == 5'd0 ? rd_byte : shift_q;

	always @* begin
		case (addr_q)
		`RCSP_ADDR_PORT_CFG: rd_byte = port_cfg_q;
		`RCSP_ADDR_SYNC_CTRL: rd_byte = sync_ctrl_q;
		`RCSP_ADDR_QEC_CTRL: rd_byte = qec_ctrl_q;
		`RCSP_ADDR_NSR_CTRL: rd_byte = nsr_ctrl_q;
		default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s <= 2'b00;
			sel_s <= 2'b11;
			dat_s <= 2'b00;
			syn_s <= 2'b00;
			sck_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
			syn_prev_q <= 1'b0;
		end else begin
			sck_s <= {sck_s[0], ser_clk};
			sel_s <= {sel_s[0], port_select_n};
			dat_s <= {dat_s[0], sdio_i};
			syn_s <= {syn_s[0], sync_in};
			sck_prev_q <= sck_s[1];
			sel_prev_q <= sel_s[1];
			syn_prev_q <= syn_s[1];
		end
	end

	// sync: optional one-shot, rearmed by clearing the enable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_resync <= 1'b0;
			sync_done_q <= 1'b0;
		end else begin
			div_resync <= 1'b0;
			if (!sync_ctrl_q[`RCSP_SYNC_EN_BIT]) begin
				sync_done_q <= 1'b0;
			end else if (syn_s[1] & ~syn_prev_q
				& ~(sync_done_q & sync_ctrl_q[`RCSP_SYNC_ONCE_BIT])) begin
				div_resync <= 1'b1;
				sync_done_q <= sync_ctrl_q[`RCSP_SYNC_ONCE_BIT];
			end
		end
	end

	// serial engine; counters persist while select is high so a pause resumes
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_q <= 16'h0000;
			bit_cnt_q <= 5'd0;
			in_data_q <= 1'b0;
			shift_q <= 8'h00;
			addr_q <= {ADDR_W{1'b0}};
			bytes_q <= 2'd0;
			done_q <= 1'b0;
			sdio_o <= 1'b0;
			sdio_oe <= 1'b0;
			port_idle_q <= 1'b1;
			port_cfg_q <= `RCSP_PORT_CFG_RST;
			sync_ctrl_q <= `RCSP_SYNC_CTRL_RST;
			qec_ctrl_q <= `RCSP_QEC_CTRL_RST;
			nsr_ctrl_q <= `RCSP_NSR_CTRL_RST;
		end else begin
			port_idle_q <= ~sel_act;
			if (!sel_act) begin
				sdio_oe <= 1'b0;
			end
			if (sel_fall && done_q) begin
				bit_cnt_q <= 5'd0;
				in_data_q <= 1'b0;
				done_q <= 1'b0;
			end else if (sel_act && sck_rise && !done_q) begin
				if (!in_data_q) begin
					instr_q <= lsb_first ? {dat_s[1], instr_q[15:1]}
						: {instr_q[14:0], dat_s[1]};
					if (bit_cnt_q == `RCSP_INSTR_BITS - 5'd1) begin
						in_data_q <= 1'b1;
						bit_cnt_q <= 5'd0;
					end else begin
						bit_cnt_q <= bit_cnt_q + 5'd1;
					end
				end else begin
					if (!rd_op) begin
						shift_q <= wr_byte; // reads keep the preloaded byte intact
					end
					if (bit_cnt_q == {1'b0, `RCSP_BYTE_BITS} - 5'd1) begin
						bit_cnt_q <= 5'd0;
						if (!rd_op) begin
							case (addr_q)
							`RCSP_ADDR_PORT_CFG: port_cfg_q <= wr_byte;
							`RCSP_ADDR_SYNC_CTRL: sync_ctrl_q <= wr_byte;
							`RCSP_ADDR_QEC_CTRL: qec_ctrl_q <= wr_byte;
							`RCSP_ADDR_NSR_CTRL: nsr_ctrl_q <= wr_byte;
							default: ;
							endcase
						end
						addr_q <= lsb_first ? addr_q + 1'b1 : addr_q - 1'b1;
						if (bytes_q == 2'd0 && instr_q[14:13] != 2'b11) begin
							done_q <= 1'b1;
						end
						bytes_q <= bytes_q - 2'd1;
					end else begin
						bit_cnt_q <= bit_cnt_q + 5'd1;
					end
				end
			end
			if (in_data_q && bit_cnt_q == 5'd0 && !done_q && sel_act && !sck_rise
				&& sck_prev_q == 1'b0 && shift_q != rd_byte && rd_op) begin
				shift_q <= rd_byte; // preload read byte at byte boundary
			end
			// address and byte count latch once the instruction is complete
			if (!in_data_q && sel_act && sck_rise && bit_cnt_q == 5'd15) begin
				addr_q <= lsb_first ? {dat_s[1], instr_q[15:4]} : {instr_q[11:0], dat_s[1]};
				bytes_q <= lsb_first ? instr_q[2:1] : instr_q[13:12];
			end
			// drive on falling clock edge so the host samples on rising
			if (sel_act && in_data_q && rd_op && !done_q && sck_fall) begin
				sdio_oe <= 1'b1;
				sdio_o <= lsb_first ? out_byte[bit_cnt_q[2:0]]
					: out_byte[3'd7 - bit_cnt_q[2:0]];
			end
		end
	end

	// control fields follow their registers
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nsr_enable <= 1'b0;
			nsr_tuning <= 2'b00;
			qec_enable <= 3'b000;
			qec_freeze <= 3'b000;
			qec_hold <= 1'b0;
			qec_valid_q <= 1'b0;
		end else begin
			nsr_enable <= nsr_ctrl_q[`RCSP_NSR_EN_BIT];
			nsr_tuning <= nsr_ctrl_q[`RCSP_NSR_EN_BIT] ? nsr_ctrl_q[2:1] : 2'b00;
			qec_enable <= qec_ctrl_q[2:0];
			qec_freeze <= qec_ctrl_q[5:3] & qec_ctrl_q[2:0];
			qec_valid_q <= |qec_ctrl_q[2:0];
			qec_hold <= qec_valid_q & (|qec_ctrl_q[2:0]);
		end
	end
endmodule // rcsp_serial_port

//--- sim/rcsp_sva.sv
// assertions on the serial port pins and control outputs
`timescale 1ns/1ps
module rcsp_sva (
	input wire core_clk, // clock
	input wire rst_n, // reset
	input wire port_select_n, // select
	input wire sdio_oe, // drive enable
	input wire port_idle_q, // idle flag
	input wire div_resync, // resync pulse
	input wire nsr_enable, // requantizer on
	input wire [1:0] nsr_tuning, // tuning
	input wire [2:0] qec_enable, // enables
	input wire [2:0] qec_freeze, // freezes
	input wire qec_hold // hold
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence sel_hi;
		port_select_n [*8];
	endsequence
	sequence sel_lo;
		!port_select_n [*8];
	endsequence
	chk_idle_rise: assert property (sel_hi |-> port_idle_q)
		else $error("idle flag low with select high");
	chk_idle_fall: assert property (sel_lo |-> !port_idle_q)
		else $error("idle flag high with select low");
	chk_float_idle: assert property (sel_hi |-> !sdio_oe)
		else $error("data line driven while deselected");
	chk_oe_select: assert property ($rose(sdio_oe) |-> !port_select_n)
		else $error("data line turned without select");
	chk_tune_gated: assert property (!nsr_enable |-> nsr_tuning == 2'b00)
		else $error("tuning set while requantizer off");
	chk_freeze_gated: assert property ((qec_freeze & ~qec_enable) == 3'b000)
		else $error("freeze on a disabled correction");
	chk_hold_on: assert property ((qec_enable != 3'b000) [*3] |-> qec_hold)
		else $error("hold low with correction enabled");
	chk_hold_off: assert property ((qec_enable == 3'b000) [*3] |-> !qec_hold)
		else $error("hold high with all corrections off");
	chk_resync_pulse: assert property (div_resync |=> !div_resync)
		else $error("resync longer than one cycle");
	chk_cfg_quiet: assert property ($changed({nsr_enable, nsr_tuning, qec_enable})
		|-> !port_idle_q)
		else $error("control changed while deselected");
endmodule // rcsp_sva
bind rcsp_serial_port rcsp_sva u_sva (.core_clk, .rst_n, .port_select_n, .sdio_oe,
	.port_idle_q, .div_resync, .nsr_enable, .nsr_tuning, .qec_enable, .qec_freeze, .qec_hold);

//--- sim/rcsp_host_model.sv
// serial host driving msb-first one-byte frames
`timescale 1ns/1ps
module rcsp_host_model (
	input wire core_clk, // clock
	input wire sdio_o, // device data
	input wire sdio_oe, // device drive
	output logic ser_clk = 1'b0, // serial clock, still outside frames
	output logic port_select_n = 1'b1, // select
	output wire sdio_i // line level
);
	logic h_en = 1'b1;
	logic h_d = 1'b0;
	// released line shows the inverse of the last host bit
	assign sdio_i = sdio_oe ? sdio_o : h_en ? h_d : ~h_d;
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] w;
		w = {rd, 2'b00, a, wd};
		port_select_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			if (i < 8 && rd)
				h_en <= 1'b0;
			h_d <= w[i];
			repeat (8) @(posedge core_clk);
			q[i % 8] = sdio_i;
			ser_clk <= 1'b1;
			repeat (8) @(posedge core_clk);
			ser_clk <= 1'b0;
		end
		repeat (8) @(posedge core_clk);
		port_select_n <= 1'b1;
		h_en <= 1'b1;
		repeat (16) @(posedge core_clk);
	endtask
endmodule // rcsp_host_model

//--- sim/rcsp_serial_port_bench.sv
// bench for the receiver configuration serial port
`timescale 1ns/1ps
`include "rcsp_defines.vh"
module rcsp_serial_port_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sync_in = 1'b0;
	wire ser_clk, port_select_n, sdio_i, sdio_o, sdio_oe, port_idle_q, div_resync;
	wire nsr_enable, qec_hold;
	wire [1:0] nsr_tuning;
	wire [2:0] qec_enable, qec_freeze;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int pulses = 0;
	logic [7:0] q;
	initial forever #50 core_clk = ~core_clk;
	rcsp_serial_port DUT (.core_clk, .rst_n, .ser_clk, .port_select_n, .sdio_i, .sdio_o,
		.sdio_oe, .port_idle_q, .sync_in, .div_resync, .nsr_enable, .nsr_tuning,
		.qec_enable, .qec_freeze, .qec_hold);
	rcsp_host_model host (.core_clk, .sdio_o, .sdio_oe, .ser_clk, .port_select_n, .sdio_i);
	task automatic test_done();
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (div_resync === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, q);
		check("readback", e, q);
	endtask
	task automatic sync_pair();
		repeat (2) begin
			sync_in <= 1'b1;
			repeat (3) @(posedge core_clk);
			sync_in <= 1'b0;
			repeat (20) @(posedge core_clk);
		end
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("idle", 8'h01, {7'h00, port_idle_q});
		rd(`RCSP_ADDR_QEC_CTRL, `RCSP_QEC_CTRL_RST);
		rd(`RCSP_ADDR_NSR_CTRL, `RCSP_NSR_CTRL_RST);
		host.xfer(1'b0, `RCSP_ADDR_QEC_CTRL, 8'h3a, q);
		check("qec", 8'h12, {2'b00, qec_freeze, qec_enable});
		check("hold", 8'h01, {7'h00, qec_hold});
		rd(`RCSP_ADDR_QEC_CTRL, 8'h3a);
		for (int t = 0; t < 3; t++) begin
			host.xfer(1'b0, `RCSP_ADDR_NSR_CTRL, {5'h00, t[1:0], 1'b1}, q);
			check("nsr", {5'h00, t[1:0], 1'b1}, {5'h00, nsr_tuning, nsr_enable});
		end
		host.xfer(1'b0, `RCSP_ADDR_NSR_CTRL, 8'h04, q);
		check("nsr off", 8'h00, {5'h00, nsr_tuning, nsr_enable});
		host.xfer(1'b0, 13'h0123, 8'h55, q);
		rd(13'h0123, 8'h00);
		host.xfer(1'b0, `RCSP_ADDR_SYNC_CTRL, 8'h03, q);
		sync_pair();
		check("sync once", 8'h01, pulses[7:0]);
		host.xfer(1'b0, `RCSP_ADDR_SYNC_CTRL, 8'h01, q);
		sync_pair();
		check("sync every", 8'h03, pulses[7:0]);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("qec reset", 8'h00, {5'h00, qec_enable});
		rd(`RCSP_ADDR_QEC_CTRL, `RCSP_QEC_CTRL_RST);
		test_done();
	end
endmodule // rcsp_serial_port_bench
